/* design/exception_vector_priority_decoder.sv */
`timescale 1ns/1ps
// Summary of operation
// - Base byte register resets to 0xff, placing vectors in the top page.
// - Reset vectors 0xfffa to 0xfffe never use the programmable base.
// - While debug firmware runs, the vector upper byte is forced to 0xff.
// - Every unmasked-by-I request outranks every I-maskable request.
// - With X mask clear, the X request preempts an I-maskable routine.
// - Among pending requests the highest vector address wins.
// - I-maskable needs local enable (die link has none), I clear, no trap/soft/X pending.
// - The vector is decided at the fetch itself, from current requests.
// - With nothing pending at fetch, answer base plus 0x80, the spurious.
// - Reset vectors fffe pin/power/address, fffc clock monitor, fffa dog.
// - Base plus f8 trap, f6 soft trap or debug, f4 X-maskable request.
// - Die link at base plus f2; other maskables f0 down to 82.
// - Every vector driven out is a full 16-bit address.
// - Base is register byte above a zero low byte, offsets added.
// - I-maskable routines only nest once software clears the I mask.
// - An I-maskable routine is preempted by any request that I does not mask, the X request only with X mask clear.
// - Non-maskable traps nest: a trap inside their handler is served.
// - I-maskable requests wake from stop or wait only with I clear.
// - Stop wake-up comes only from asynchronously asserted requests.
module exception_vector_priority_decoder #(
    parameter int NUM_IRQ = 56,
    parameter int IRQ_IW  = 6
) (
    input  wire logic                   CLK,
    input  wire logic                   RST,
    // Register bus
    input  wire logic [3:0]             AXI_AWADDR,
    input  wire logic                   AXI_AWVALID,
    output logic                        AXI_AWREADY,
    input  wire logic [31:0]            AXI_WDATA,
    input  wire logic [3:0]             AXI_WSTRB,
    input  wire logic                   AXI_WVALID,
    output logic                        AXI_WREADY,
    output logic [1:0]                  AXI_BRESP,
    output logic                        AXI_BVALID,
    input  wire logic                   AXI_BREADY,
    input  wire logic [3:0]             AXI_ARADDR,
    input  wire logic                   AXI_ARVALID,
    output logic                        AXI_ARREADY,
    output logic [31:0]                 AXI_RDATA,
    output logic [1:0]                  AXI_RRESP,
    output logic                        AXI_RVALID,
    input  wire logic                   AXI_RREADY,
    // Exception sources
    input  wire logic                   PIN_RESET_REQ,
    input  wire logic                   CLK_MON_RESET_REQ,
    input  wire logic                   WATCHDOG_TIMEOUT,
    input  wire logic                   ILLEGAL_OPCODE_TRAP,
    input  wire logic                   SOFTWARE_TRAP_REQUEST,
    input  wire logic                   DEBUG_ENTRY_REQ,
    input  wire logic                   XIRQ_REQ,
    input  wire logic                   DIE_LINK_IRQ,
    input  wire logic [NUM_IRQ-1:0]     IRQ_REQ,
    input  wire logic [NUM_IRQ-1:0]     IRQ_ENABLE,
    // CPU side
    input  wire logic                   IRQ_MASK_BIT,
    input  wire logic                   XIRQ_MASK_BIT,
    input  wire logic                   BACKGROUND_DEBUG_MODE,
    input  wire logic                   VECTOR_FETCH,
    output logic [15:0]                 VECTOR_ADDR,
    output logic                        VECTOR_VALID,
    output logic                        INTERRUPT_PENDING,
    output logic                        WAKEUP
);

    // --------------------------------------------------------
    // Elaboration check
    // --------------------------------------------------------
    if (NUM_IRQ < 1 || NUM_IRQ > vector_decoder_pkg::MAX_IRQ
        || (1 << IRQ_IW) < NUM_IRQ)
    begin : g_bad
        $error("NUM_IRQ out of the slot range 0x82..0xf0");
    end

    // --------------------------------------------------------
    // State
    // --------------------------------------------------------
    typedef struct packed {
        logic [7:0]                      base;
        logic [15:0]                     vector;
        logic                            vector_valid;
        logic                            spurious;
        vector_decoder_pkg::chan_state_t wr;
        logic                            aw_got;
        logic                            w_got;
        logic [3:0]                      awaddr;
        logic [31:0]                     wdata;
        logic [3:0]                      wstrb;
        logic [1:0]                      bresp;
        vector_decoder_pkg::chan_state_t rd;
        logic [31:0]                     rdata;
        logic [1:0]                      rresp;
    } state_t;

    state_t               st;
    state_t               next_st;
    logic                 reset_any;
    logic                 x_live;
    logic                 nonmask_any;
    logic [NUM_IRQ-1:0]   irq_live;
    logic                 irq_found;
    logic [IRQ_IW-1:0]    irq_index;
    logic                 imask_ok;
    logic                 grant_any;
    logic [7:0]           base_used;
    logic [15:0]          vector_now;
    logic                 wake;
    logic                 aw_now;
    logic                 w_now;
    logic [3:0]           wr_addr;
    logic [31:0]          wr_data;
    logic [3:0]           wr_strb;

    // Join the base byte and a table offset into a full address
    function automatic logic [15:0] vec_of(input logic [7:0] hi,
                                           input logic [7:0] ofs);
        vec_of = {hi, vector_decoder_pkg::LOW_ZERO} + {8'h00, ofs};
    endfunction

    // --------------------------------------------------------
    // Qualification of requests
    // --------------------------------------------------------
    assign reset_any   = PIN_RESET_REQ | CLK_MON_RESET_REQ
                       | WATCHDOG_TIMEOUT;
    assign x_live      = XIRQ_REQ & ~XIRQ_MASK_BIT;
    // Traps ignore every mask, so they nest inside their own handlers
    assign nonmask_any = ILLEGAL_OPCODE_TRAP | SOFTWARE_TRAP_REQUEST
                       | DEBUG_ENTRY_REQ;
    assign irq_live    = IRQ_REQ & IRQ_ENABLE;
    assign imask_ok    = ~IRQ_MASK_BIT & ~nonmask_any & ~x_live;
    assign base_used   = BACKGROUND_DEBUG_MODE
                       ? vector_decoder_pkg::BASE_DEBUG : st.base;
    assign grant_any   = reset_any | nonmask_any | x_live
                       | (imask_ok & (DIE_LINK_IRQ | irq_found));

    highest_request_picker #(
        .N      (NUM_IRQ),
        .IW     (IRQ_IW)
    ) u_picker (
        .req    (irq_live),
        .found  (irq_found),
        .index  (irq_index)
    );

    stop_wake_gate #(
        .N             (NUM_IRQ)
    ) u_wake (
        .irq_req       (IRQ_REQ),
        .irq_enable    (IRQ_ENABLE),
        .die_link_irq  (DIE_LINK_IRQ),
        .irq_mask_bit  (IRQ_MASK_BIT),
        .xirq_req      (XIRQ_REQ),
        .xirq_mask_bit (XIRQ_MASK_BIT),
        .wake          (wake)
    );

    // --------------------------------------------------------
    // Priority chain, highest vector first
    // --------------------------------------------------------
    // Decided in the fetch cycle, never latched at recognition time
    always_comb
    begin
        if (PIN_RESET_REQ)
            vector_now = vector_decoder_pkg::VEC_PIN_RESET;
        else if (CLK_MON_RESET_REQ)
            vector_now = vector_decoder_pkg::VEC_CLK_MON;
        else if (WATCHDOG_TIMEOUT)
            vector_now = vector_decoder_pkg::VEC_WATCHDOG;
        else if (ILLEGAL_OPCODE_TRAP)
            vector_now = vec_of(base_used,
                                vector_decoder_pkg::OFS_TRAP);
        else if (SOFTWARE_TRAP_REQUEST | DEBUG_ENTRY_REQ)
            vector_now = vec_of(base_used,
                                vector_decoder_pkg::OFS_SOFT);
        else if (x_live)
            vector_now = vec_of(base_used,
                                vector_decoder_pkg::OFS_XIRQ);
        else if (imask_ok & DIE_LINK_IRQ)
            vector_now = vec_of(base_used,
                                vector_decoder_pkg::OFS_DIE_LINK);
        else if (imask_ok & irq_found)
            vector_now = vec_of(base_used,
                8'(vector_decoder_pkg::OFS_IRQ_LOW
                   + (8'(irq_index) << 1)));
        else
            vector_now = vec_of(base_used,
                                vector_decoder_pkg::OFS_SPURIOUS);
    end

    // --------------------------------------------------------
    // Write channel inputs, either order
    // --------------------------------------------------------
    assign AXI_AWREADY = (st.wr == vector_decoder_pkg::CH_IDLE) & ~st.aw_got;
    assign AXI_WREADY  = (st.wr == vector_decoder_pkg::CH_IDLE) & ~st.w_got;
    assign aw_now      = st.aw_got | (AXI_AWVALID & AXI_AWREADY);
    assign w_now       = st.w_got | (AXI_WVALID & AXI_WREADY);
    assign wr_addr     = st.aw_got ? st.awaddr : AXI_AWADDR;
    assign wr_data     = st.w_got ? st.wdata : AXI_WDATA;
    assign wr_strb     = st.w_got ? st.wstrb : AXI_WSTRB;

    // --------------------------------------------------------
    // Next state
    // --------------------------------------------------------
    always_comb
    begin
        next_st = st;
        // Vector answer is a one-cycle strobe per fetch
        next_st.vector_valid = VECTOR_FETCH;
        if (VECTOR_FETCH)
        begin
            next_st.vector   = vector_now;
            next_st.spurious = ~grant_any;
        end

        // Write: wait for address and data, then answer
        unique case (st.wr)
            vector_decoder_pkg::CH_IDLE:
            begin
                next_st.aw_got = aw_now;
                next_st.w_got  = w_now;
                next_st.awaddr = wr_addr;
                next_st.wdata  = wr_data;
                next_st.wstrb  = wr_strb;
                if (aw_now & w_now)
                begin
                    next_st.aw_got = 1'b0;
                    next_st.w_got  = 1'b0;
                    next_st.wr     = vector_decoder_pkg::CH_BUSY;
                    next_st.bresp  = vector_decoder_pkg::RESP_OKAY;
                    if (wr_addr == vector_decoder_pkg::ADDR_BASE)
                    begin
                        // New base seen by the first fetch after this edge
                        if (wr_strb[0])
                            next_st.base = wr_data[7:0];
                    end
                    else if (wr_addr != vector_decoder_pkg::ADDR_STATUS)
                        next_st.bresp = vector_decoder_pkg::RESP_SLVERR;
                end
            end
            vector_decoder_pkg::CH_BUSY:
            begin
                if (AXI_BREADY)
                    next_st.wr = vector_decoder_pkg::CH_IDLE;
            end
        endcase

        // Read: one cycle from address to data
        unique case (st.rd)
            vector_decoder_pkg::CH_IDLE:
            begin
                if (AXI_ARVALID)
                begin
                    next_st.rd    = vector_decoder_pkg::CH_BUSY;
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = vector_decoder_pkg::RESP_OKAY;
                    if (AXI_ARADDR == vector_decoder_pkg::ADDR_BASE)
                        next_st.rdata[7:0] = st.base;
                    else if (AXI_ARADDR == vector_decoder_pkg::ADDR_STATUS)
                    begin
                        next_st.rdata[15:0] = st.vector;
                        next_st.rdata[vector_decoder_pkg::ST_SPURIOUS] =
                            st.spurious;
                        next_st.rdata[vector_decoder_pkg::ST_PENDING] =
                            grant_any;
                        next_st.rdata[vector_decoder_pkg::ST_WAKE] = wake;
                    end
                    else
                        next_st.rresp = vector_decoder_pkg::RESP_SLVERR;
                end
            end
            vector_decoder_pkg::CH_BUSY:
            begin
                if (AXI_RREADY)
                    next_st.rd = vector_decoder_pkg::CH_IDLE;
            end
        endcase
    end

    // --------------------------------------------------------
    // Registers
    // --------------------------------------------------------
    // Base is reloaded by reset before any reset vector can be formed
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            st        <= '0;
            st.base   <= vector_decoder_pkg::BASE_RESET;
            st.vector <= vector_decoder_pkg::VEC_PIN_RESET;
            st.wr     <= vector_decoder_pkg::CH_IDLE;
            st.rd     <= vector_decoder_pkg::CH_IDLE;
        end
        else
            st <= next_st;
    end

    // --------------------------------------------------------
    // Outputs
    // --------------------------------------------------------
    assign VECTOR_ADDR       = st.vector;
    assign VECTOR_VALID      = st.vector_valid;
    assign INTERRUPT_PENDING = grant_any & ~reset_any;
    // Wake path bypasses every flip-flop; the clock may be stopped
    assign WAKEUP            = wake;
    assign AXI_BVALID        = st.wr == vector_decoder_pkg::CH_BUSY;
    assign AXI_BRESP         = st.bresp;
    assign AXI_ARREADY       = st.rd == vector_decoder_pkg::CH_IDLE;
    assign AXI_RVALID        = st.rd == vector_decoder_pkg::CH_BUSY;
    assign AXI_RDATA         = st.rdata;
    assign AXI_RRESP         = st.rresp;

    // --------------------------------------------------------
    // Assertions
    // --------------------------------------------------------
    property p_base_reset;
        @(posedge CLK) disable iff (RST)
        $past(RST) |-> st.base == vector_decoder_pkg::BASE_RESET;
    endproperty
    a_base_reset: assert property (p_base_reset)
        else $error("Base byte not 0xff after reset");

    property p_reset_vec;
        @(posedge CLK) disable iff (RST)
        VECTOR_FETCH && PIN_RESET_REQ
        |=> VECTOR_ADDR == vector_decoder_pkg::VEC_PIN_RESET;
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("Pin reset vector not fixed");

    property p_debug_base;
        @(posedge CLK) disable iff (RST)
        VECTOR_FETCH && BACKGROUND_DEBUG_MODE && !reset_any
        |=> VECTOR_ADDR[15:8] == vector_decoder_pkg::BASE_DEBUG;
    endproperty
    a_debug_base: assert property (p_debug_base)
        else $error("Base not forced in debug");

    property p_x_over_i;
        @(posedge CLK) disable iff (RST)
        VECTOR_FETCH && x_live && !reset_any && !nonmask_any
        |=> VECTOR_ADDR == {$past(base_used), vector_decoder_pkg::OFS_XIRQ};
    endproperty
    a_x_over_i: assert property (p_x_over_i)
        else $error("X request did not win");

    property p_trap_first;
        @(posedge CLK) disable iff (RST)
        VECTOR_FETCH && ILLEGAL_OPCODE_TRAP && SOFTWARE_TRAP_REQUEST
        && !reset_any
        |=> VECTOR_ADDR[7:0] == vector_decoder_pkg::OFS_TRAP;
    endproperty
    a_trap_first: assert property (p_trap_first)
        else $error("Higher vector did not win");

    property p_masked_i;
        @(posedge CLK) disable iff (RST)
        VECTOR_FETCH && IRQ_MASK_BIT && !reset_any && !nonmask_any
        && !x_live
        |=> VECTOR_ADDR[7:0] == vector_decoder_pkg::OFS_SPURIOUS;
    endproperty
    a_masked_i: assert property (p_masked_i)
        else $error("Masked request was granted");

    property p_strobe;
        @(posedge CLK) disable iff (RST)
        VECTOR_FETCH |=> VECTOR_VALID ##1 !VECTOR_VALID || $past(VECTOR_FETCH);
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("Vector strobe does not follow fetch");

    property p_spurious;
        @(posedge CLK) disable iff (RST)
        VECTOR_FETCH && !grant_any
        |=> VECTOR_ADDR == {$past(base_used),
                            vector_decoder_pkg::OFS_SPURIOUS};
    endproperty
    a_spurious: assert property (p_spurious)
        else $error("Spurious vector wrong");

    property p_no_wake;
        @(posedge CLK) disable iff (RST)
        IRQ_MASK_BIT && !x_live |-> !WAKEUP;
    endproperty
    a_no_wake: assert property (p_no_wake)
        else $error("Wake-up while I mask set");

    property p_base_write;
        @(posedge CLK) disable iff (RST)
        st.wr == vector_decoder_pkg::CH_IDLE && aw_now && w_now
        && wr_addr == vector_decoder_pkg::ADDR_BASE && wr_strb[0]
        |=> st.base == $past(wr_data[7:0]);
    endproperty
    a_base_write: assert property (p_base_write)
        else $error("Base write did not land");

endmodule

/* design/highest_request_picker.sv */
`timescale 1ns/1ps
// Picks the set request with the highest index, which is the one with
// the highest vector slot.
module highest_request_picker #(
    parameter int N  = 56,
    parameter int IW = 6
) (
    input  wire logic [N-1:0]  req,
    output logic               found,
    output logic [IW-1:0]      index
);

    // --------------------------------------------------------
    // Elaboration check
    // --------------------------------------------------------
    if (N < 1 || (1 << IW) < N)
    begin : g_bad
        $error("Index width too small for request count");
    end

    // --------------------------------------------------------
    // Scan upward so the last hit is the highest
    // --------------------------------------------------------
    always_comb
    begin
        found = 1'b0;
        index = '0;
        for (int i = 0; i < N; i++)
        begin
            if (req[i])
            begin
                found = 1'b1;
                index = IW'(i);
            end
        end
    end

endmodule

/* design/stop_wake_gate.sv */
`timescale 1ns/1ps
// Purely combinational wake-up path. No clock runs in stop, so nothing
// here may pass through a flip-flop.
module stop_wake_gate #(
    parameter int N = 56
) (
    input  wire logic [N-1:0]  irq_req,
    input  wire logic [N-1:0]  irq_enable,
    input  wire logic          die_link_irq,
    input  wire logic          irq_mask_bit,
    input  wire logic          xirq_req,
    input  wire logic          xirq_mask_bit,
    output logic               wake
);

    logic maskable_any;

    // --------------------------------------------------------
    // Same qualification as in run mode
    // --------------------------------------------------------
    assign maskable_any = (|(irq_req & irq_enable)) | die_link_irq;
    assign wake = (maskable_any & ~irq_mask_bit)
                | (xirq_req & ~xirq_mask_bit);

endmodule

/* design/vector_decoder_pkg.sv */
package vector_decoder_pkg;

    // ------------------------------------------------------------
    // Vector layout
    // ------------------------------------------------------------
    localparam logic [7:0]  BASE_RESET    = 8'hff; // Base byte after reset
    localparam logic [7:0]  BASE_DEBUG    = 8'hff; // Forced base in debug
    localparam logic [7:0]  LOW_ZERO      = 8'h00; // Low byte of the base
    localparam logic [15:0] VEC_PIN_RESET = 16'hfffe;
    localparam logic [15:0] VEC_CLK_MON   = 16'hfffc;
    localparam logic [15:0] VEC_WATCHDOG  = 16'hfffa;
    localparam logic [7:0]  OFS_TRAP      = 8'hf8;
    localparam logic [7:0]  OFS_SOFT      = 8'hf6;
    localparam logic [7:0]  OFS_XIRQ      = 8'hf4;
    localparam logic [7:0]  OFS_DIE_LINK  = 8'hf2;
    localparam logic [7:0]  OFS_IRQ_LOW   = 8'h82; // Lowest maskable slot
    localparam logic [7:0]  OFS_SPURIOUS  = 8'h80;
    localparam int          MAX_IRQ       = 56;    // Slots 0x82..0xf0

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          AXI_ADDR_W    = 4;
    localparam logic [3:0]  ADDR_BASE     = 4'h0;  // vector_base_byte
    localparam logic [3:0]  ADDR_STATUS   = 4'h4;  // Read-only status
    localparam int          ST_SPURIOUS   = 16;    // Last fetch was spurious
    localparam int          ST_PENDING    = 17;    // Some request qualified
    localparam int          ST_WAKE       = 18;    // Wake-up is asserted
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ------------------------------------------------------------
    // Bus channel states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CH_IDLE = 2'b01,
        CH_BUSY = 2'b10
    } chan_state_t;

endpackage

/* verif/cpu_vector_requester.sv */
`timescale 1ns/1ps
// CPU side of the vector port: one fetch pulse a cycle after each trigger
module cpu_vector_requester (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic trig,
    output logic      fetch
);
    // Requests stay held by the bench until this fetch is served
    always_ff @(posedge clk)
    begin
        fetch <= !rst && trig;
    end
endmodule

/* verif/exception_vector_priority_decoder_tb.sv */
`timescale 1ns/1ps
module exception_vector_priority_decoder_tb;
    logic        CLK, RST, TRIG, AXI_AWVALID, AXI_WVALID, AXI_BREADY;
    logic        AXI_ARVALID, AXI_RREADY, IRQ_MASK_BIT, XIRQ_MASK_BIT;
    logic        BACKGROUND_DEBUG_MODE, AXI_AWREADY, AXI_WREADY;
    logic        AXI_BVALID, AXI_ARREADY, AXI_RVALID, VECTOR_VALID;
    logic        INTERRUPT_PENDING, WAKEUP;
    logic [3:0]  AXI_AWADDR, AXI_ARADDR;
    logic [3:0]  AXI_WSTRB = 4'hf;
    logic [31:0] AXI_WDATA, AXI_RDATA;
    logic [1:0]  AXI_BRESP, AXI_RRESP;
    logic [55:0] IRQ_REQ, IRQ_ENABLE;
    logic [15:0] VECTOR_ADDR;
    logic [7:0]  SRC;
    wire         PIN_RESET_REQ, CLK_MON_RESET_REQ, WATCHDOG_TIMEOUT;
    wire         ILLEGAL_OPCODE_TRAP, SOFTWARE_TRAP_REQUEST, XIRQ_REQ;
    wire         DEBUG_ENTRY_REQ, DIE_LINK_IRQ, VECTOR_FETCH;
    int          fail_count = 0, checks_done = 0, a, b;
    logic [15:0] expq [$];
    logic [31:0] seed = 32'he8e8;
    logic [7:0]  lo [8] = '{8'hfe, 8'hfc, 8'hfa, 8'hf8, 8'hf6, 8'hf6,
                            8'hf4, 8'hf2};
    // Source bits ordered from the highest vector to the lowest
    assign {DIE_LINK_IRQ, XIRQ_REQ, DEBUG_ENTRY_REQ, SOFTWARE_TRAP_REQUEST,
            ILLEGAL_OPCODE_TRAP, WATCHDOG_TIMEOUT, CLK_MON_RESET_REQ,
            PIN_RESET_REQ} = SRC;
    exception_vector_priority_decoder dut_u (.*);
    cpu_vector_requester cpu_u (.clk(CLK), .rst(RST), .trig(TRIG),
                                .fetch(VECTOR_FETCH));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk_vec(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %0t vector %h want %h", $time, g, e);
        end
    endtask
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %0t value %h want %h", $time, g, e);
        end
    endtask
    // Sources settle first, then the CPU model asks for the vector
    task automatic go(input logic [7:0] s, input logic [55:0] r,
                      input logic [15:0] e);
        @(posedge CLK);
        SRC <= s;
        IRQ_REQ <= r;
        @(posedge CLK);
        TRIG <= 1'b1;
        expq.push_back(e);
        @(posedge CLK);
        TRIG <= 1'b0;
        repeat (3) @(posedge CLK);
    endtask
    task automatic axi_wr(input logic [3:0] ad, input logic [31:0] d,
                          input logic [1:0] r);
        @(posedge CLK);
        {AXI_AWADDR, AXI_WDATA} <= {ad, d};
        {AXI_AWVALID, AXI_WVALID, AXI_BREADY} <= 3'b111;
        do
        begin
            @(posedge CLK);
            if (AXI_AWREADY === 1'b1) AXI_AWVALID <= 1'b0;
            if (AXI_WREADY === 1'b1) AXI_WVALID <= 1'b0;
        end while (AXI_BVALID !== 1'b1);
        AXI_BREADY <= 1'b0;
        chk_reg(32'(AXI_BRESP), 32'(r));
    endtask
    task automatic axi_rd(input logic [3:0] ad, input logic [31:0] d,
                          input logic [1:0] r);
        @(posedge CLK);
        {AXI_ARADDR, AXI_ARVALID, AXI_RREADY} <= {ad, 2'b11};
        do
        begin
            @(posedge CLK);
            if (AXI_ARREADY === 1'b1) AXI_ARVALID <= 1'b0;
        end while (AXI_RVALID !== 1'b1);
        AXI_RREADY <= 1'b0;
        chk_reg(AXI_RDATA, d);
        chk_reg(32'(AXI_RRESP), 32'(r));
    endtask
    task automatic end_of_test();
        // An expected vector that never came back is a failure too
        if (expq.size() != 0)
            fail_count++;
        $display("checks %0d failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        CLK = 0;
        forever #10 CLK = ~CLK;
    end
    // Each delivered vector is matched against the oldest expectation
    always @(posedge CLK)
        if (!RST && VECTOR_VALID === 1'b1)
            chk_vec(VECTOR_ADDR, expq.size() ? expq.pop_front() : 'x);
    // A hang ends the run as a failure
    initial
    begin
        repeat (20000) @(posedge CLK);
        fail_count++;
        end_of_test();
    end
    initial
    begin
        {RST, TRIG, SRC, IRQ_REQ, IRQ_ENABLE} = {2'b10, 120'h0};
        {AXI_AWVALID, AXI_WVALID, AXI_BREADY, AXI_ARVALID} = 4'h0;
        {AXI_RREADY, IRQ_MASK_BIT, XIRQ_MASK_BIT} = 3'h0;
        {BACKGROUND_DEBUG_MODE, AXI_AWADDR, AXI_ARADDR, AXI_WDATA} = '0;
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        axi_rd(4'h0, 32'hff, 2'h0);
        go(8'h00, '0, 16'hff80);
        axi_wr(4'h0, 32'h12, 2'h0);
        axi_wr(4'h8, 32'h0, 2'h2);
        AXI_WSTRB <= 4'he;
        axi_wr(4'h0, 32'h34, 2'h0);
        AXI_WSTRB <= 4'hf;
        axi_wr(4'h4, 32'h56, 2'h0);
        axi_rd(4'h0, 32'h12, 2'h0);
        axi_rd(4'hc, 32'h0, 2'h2);
        go(8'h00, '0, 16'h1280);
        IRQ_ENABLE <= '1;
        for (int i = 0; i < 8; i++)
        begin
            go(8'h1 << i, '0, {i < 3 ? 8'hff : 8'h12, lo[i]});
            go(8'hff << i, '1, {i < 3 ? 8'hff : 8'h12, lo[i]});
        end
        BACKGROUND_DEBUG_MODE <= 1'b1;
        go(8'h10, '0, 16'hfff6);
        BACKGROUND_DEBUG_MODE <= 1'b0;
        for (int k = 0; k < 6; k++)
        begin
            a = int'(rnd() % 56);
            b = int'(rnd() % 56);
            go(8'h00, (56'h1 << a) | (56'h1 << b),
               {8'h12, 8'h82 + 8'(2 * (a > b ? a : b))});
            chk_reg(32'(WAKEUP), 32'h1);
            chk_reg(32'(INTERRUPT_PENDING), 32'h1);
        end
        IRQ_MASK_BIT <= 1'b1;
        go(8'h00, 56'h1, 16'h1280);
        chk_reg(32'(WAKEUP), 32'h0);
        chk_reg(32'(INTERRUPT_PENDING), 32'h0);
        axi_rd(4'h4, 32'h0001_1280, 2'h0);
        IRQ_MASK_BIT <= 1'b0;
        go(8'h40, 56'h1, 16'h12f4);
        XIRQ_MASK_BIT <= 1'b1;
        go(8'h40, 56'h1, 16'h1282);
        go(8'h10, 56'h1, 16'h12f6);
        IRQ_ENABLE <= '0;
        go(8'h00, 56'h1, 16'h1280);
        chk_reg(32'(WAKEUP), 32'h0);
        end_of_test();
    end
endmodule
